// File: core/icp_consts.svh
// Constants for the serial configuration register port.
`ifndef ICP_CONSTS_SVH
`define ICP_CONSTS_SVH

`define ICP_NBYTES 256
`define ICP_RDLOCK_BYTE 8'he5
`define ICP_RDLOCK_BIT 0
`define ICP_LOCK_BYTE 8'he9
`define ICP_WRLOW_BIT 7
`define ICP_WRALL_BIT 6
`define ICP_CODE_MSB 3
`define ICP_CODE_LSB 0
`define ICP_LOW_BANK_END 8'hc0
`define ICP_LOCKED_DATA 8'hff
`define ICP_LIVE0_FIRST 8'hf0
`define ICP_LIVE0_LAST 8'hf3
`define ICP_LIVE1_FIRST 8'hf5
`define ICP_LIVE1_LAST 8'hf7
`define ICP_BIT_COUNT 4'h8

`endif

// File: core/icp_pkg.sv
// Types shared by the serial configuration register port.
package icp_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CTRL,
		ST_WORD,
		ST_WDATA,
		ST_ACK,
		ST_RDATA,
		ST_MACK
	} icp_state_t;

	typedef struct packed {
		logic en;
		logic [10:0] addr;
		logic [7:0] data;
	} icp_wr_t;

endpackage

// File: core/icp_regfile.sv
// Volatile configuration byte store with protection and live readback.
`timescale 1ns/1ps
`include "icp_consts.svh"

module icp_regfile
	import icp_pkg::*;
#(
	parameter int NBYTES = `ICP_NBYTES,
	parameter int LIVE_W = 56
)
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rstn,
	// Stored image and live levels.
	input wire logic [NBYTES*8-1:0] i_nvm_image,
	input wire logic [LIVE_W-1:0] i_live,
	// Access from the serial engine.
	input wire icp_wr_t i_wr,
	input wire logic [10:0] i_rd_addr,
	output logic [7:0] o_rdata,
	// Configuration out.
	output logic [NBYTES*8-1:0] o_image,
	output logic [3:0] o_code,
	output logic o_loaded
);

	logic [7:0] mem [0:NBYTES-1];
	logic loaded;

	// ----------------------------------------
	// Write protection
	// ----------------------------------------
	function automatic logic byte_writable(input logic [7:0] a);
		byte_writable = (a <= 8'h6d) || (a >= 8'h80 && a <= 8'hba) ||
			(a >= 8'hc0 && a <= 8'hdf) || a == 8'he4 || a == 8'he6 || a == 8'hf4;
	endfunction

	wire lock_rd = mem[`ICP_RDLOCK_BYTE][`ICP_RDLOCK_BIT];
	wire lock_wr_all = mem[`ICP_LOCK_BYTE][`ICP_WRALL_BIT];
	wire lock_wr_low = mem[`ICP_LOCK_BYTE][`ICP_WRLOW_BIT];
	wire in_range = i_wr.addr[10:8] == 3'h0;
	wire low_bank = i_wr.addr[7:0] < `ICP_LOW_BANK_END;
	// Write-all lock wins; the lower-bank lock only matters without it.
	wire wr_blocked = lock_wr_all || (lock_wr_low && low_bank);
	wire wr_ok = loaded && i_wr.en && in_range && !wr_blocked
		&& byte_writable(i_wr.addr[7:0]);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			loaded <= 1'b0;
		else
			loaded <= 1'b1;
	end

	genvar g;
	generate
		for (g = 0; g < NBYTES; g++)
		begin : g_byte
			always_ff @(posedge i_clk)
			begin
				if (!i_rstn)
					mem[g] <= 8'h00;
				else if (!loaded)
					mem[g] <= i_nvm_image[g*8 +: 8];
				else if (wr_ok && i_wr.addr[7:0] == 8'(g))
					mem[g] <= i_wr.data;
			end
			assign o_image[g*8 +: 8] = mem[g];
		end
	endgenerate

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire [7:0] ra = i_rd_addr[7:0];
	wire rd_out = i_rd_addr[10:8] != 3'h0;
	wire rd_locked = lock_rd && ra < `ICP_LOW_BANK_END;
	wire live0 = ra >= `ICP_LIVE0_FIRST && ra <= `ICP_LIVE0_LAST;
	wire live1 = ra >= `ICP_LIVE1_FIRST && ra <= `ICP_LIVE1_LAST;
	wire [7:0] live0_byte = i_live[(ra - `ICP_LIVE0_FIRST)*8 +: 8];
	wire [7:0] live1_byte = i_live[32 + (ra - `ICP_LIVE1_FIRST)*8 +: 8];

	assign o_rdata = (rd_out || rd_locked) ? `ICP_LOCKED_DATA :
		live0 ? live0_byte : live1 ? live1_byte : mem[ra];
	assign o_code = mem[`ICP_LOCK_BYTE][`ICP_CODE_MSB:`ICP_CODE_LSB];
	assign o_loaded = loaded;

endmodule

// File: core/icp_port.sv
// Serial target that reads and writes the volatile configuration registers.
`timescale 1ns/1ps
`include "icp_consts.svh"

module icp_port
	import icp_pkg::*;
#(
	parameter int NBYTES = `ICP_NBYTES,
	parameter int LIVE_W = 56
)
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rstn,
	// Serial pins.
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe,
	// Stored image and live macrocell levels.
	input wire logic [NBYTES*8-1:0] i_nvm_image,
	input wire logic [LIVE_W-1:0] i_macro_levels,
	// Configuration and status out.
	output logic [NBYTES*8-1:0] o_cfg_image,
	output logic o_cfg_loaded,
	output logic o_busy
);

	// ----------------------------------------
	// Pin synchronisers and bus events
	// ----------------------------------------
	logic scl_s1, scl_s2, scl_d;
	logic sda_s1, sda_s2, sda_d;

	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_s1 <= i_scl;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= i_sda;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	wire rise = scl_s2 && !scl_d;
	wire fall = !scl_s2 && scl_d;
	wire start = scl_s2 && scl_d && sda_d && !sda_s2;
	wire stop = scl_s2 && scl_d && !sda_d && sda_s2;

	// ----------------------------------------
	// Engine state
	// ----------------------------------------
	icp_state_t state, next_state, after, next_after;
	logic [3:0] cnt, next_cnt;
	logic [7:0] sh, next_sh;
	logic [7:0] tx, next_tx;
	logic [10:0] ptr, next_ptr;
	logic [2:0] blk, next_blk;
	logic wflag, next_wflag;
	logic adv, next_adv;
	logic next_oe;
	icp_wr_t wr, next_wr;
	logic [7:0] rdata;
	logic [3:0] code;

	wire [10:0] ptr_inc = ptr + 11'h001;
	wire [10:0] rd_addr = (state == ST_MACK) ? ptr_inc : ptr;
	wire [10:0] wr_addr = adv ? ptr_inc : ptr;

	icp_regfile #(
		.NBYTES(NBYTES),
		.LIVE_W(LIVE_W)
	) u_regs (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_nvm_image(i_nvm_image),
		.i_live(i_macro_levels),
		.i_wr(wr),
		.i_rd_addr(rd_addr),
		.o_rdata(rdata),
		.o_image(o_cfg_image),
		.o_code(code),
		.o_loaded(o_cfg_loaded)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		next_after = after;
		next_cnt = cnt;
		next_sh = sh;
		next_tx = tx;
		next_ptr = ptr;
		next_blk = blk;
		next_wflag = wflag;
		next_adv = adv;
		next_oe = o_sda_oe;
		next_wr = '0;
		if (start)
		begin
			// A repeated start ends a write half but keeps the pointer.
			next_state = ST_CTRL;
			next_cnt = 4'h0;
			next_oe = 1'b0;
		end
		else if (stop)
		begin
			next_state = ST_IDLE;
			next_oe = 1'b0;
			if (wflag)
			begin
				next_ptr = ptr_inc;
				next_wflag = 1'b0;
			end
		end
		else
		begin
			case (state)
				ST_CTRL, ST_WORD, ST_WDATA:
				begin
					if (rise && cnt != `ICP_BIT_COUNT)
					begin
						next_sh = {sh[6:0], sda_s2};
						next_cnt = cnt + 4'h1;
					end
					if (fall && cnt == `ICP_BIT_COUNT)
					begin
						next_oe = 1'b1;
						next_state = ST_ACK;
						if (state == ST_CTRL)
						begin
							if (sh[7:4] != code)
							begin
								next_oe = 1'b0;
								next_state = ST_IDLE;
							end
							else
							begin
								next_blk = sh[3:1];
								if (sh[0])
									next_after = ST_RDATA;
								else
								begin
									next_after = ST_WORD;
									next_wflag = 1'b1;
									next_adv = 1'b0;
								end
							end
						end
						else if (state == ST_WORD)
						begin
							next_ptr = {blk, sh};
							next_after = ST_WDATA;
						end
						else
						begin
							next_ptr = wr_addr;
							next_adv = 1'b1;
							next_wr.en = 1'b1;
							next_wr.addr = wr_addr;
							next_wr.data = sh;
							next_after = ST_WDATA;
						end
					end
				end
				ST_ACK:
				begin
					if (fall)
					begin
						next_cnt = 4'h0;
						next_state = after;
						next_oe = 1'b0;
						if (after == ST_RDATA)
						begin
							next_oe = !rdata[7];
							next_tx = {rdata[6:0], 1'b0};
						end
					end
				end
				ST_RDATA:
				begin
					if (rise)
						next_cnt = cnt + 4'h1;
					if (fall)
					begin
						if (cnt == `ICP_BIT_COUNT)
						begin
							next_oe = 1'b0;
							next_state = ST_MACK;
						end
						else
						begin
							next_oe = !tx[7];
							next_tx = {tx[6:0], 1'b0};
						end
					end
				end
				ST_MACK:
				begin
					if (rise && sda_s2)
						next_state = ST_IDLE;
					else if (fall)
					begin
						// Acknowledged: the next byte comes from the next address.
						next_ptr = ptr_inc;
						next_cnt = 4'h0;
						next_oe = !rdata[7];
						next_tx = {rdata[6:0], 1'b0};
						next_state = ST_RDATA;
					end
				end
				default:
				begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			state <= ST_IDLE;
			after <= ST_IDLE;
			cnt <= 4'h0;
			sh <= 8'h00;
			tx <= 8'h00;
			ptr <= 11'h000;
			blk <= 3'h0;
			wflag <= 1'b0;
			adv <= 1'b0;
			wr <= '0;
		end
		else
		begin
			state <= next_state;
			after <= next_after;
			cnt <= next_cnt;
			sh <= next_sh;
			tx <= next_tx;
			ptr <= next_ptr;
			blk <= next_blk;
			wflag <= next_wflag;
			adv <= next_adv;
			wr <= next_wr;
		end
	end

	// Open-drain: the pin is only ever pulled low, so the data bit stays zero.
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			o_sda_o <= 1'b0;
			o_sda_oe <= 1'b0;
			o_busy <= 1'b0;
		end
		else
		begin
			o_sda_o <= 1'b0;
			o_sda_oe <= next_oe;
			o_busy <= next_state != ST_IDLE;
		end
	end

endmodule

// File: bench/icp_port_chk.sv
// Assertion checker for the serial configuration port.
`timescale 1ns/1ps
module icp_port_chk
#(
	parameter int NBYTES = 256,
	parameter int LIVE_W = 56
)
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rstn,
	// Serial pins.
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda_o,
	input wire logic o_sda_oe,
	// Image, levels and status.
	input wire logic [NBYTES*8-1:0] i_nvm_image,
	input wire logic [LIVE_W-1:0] i_macro_levels,
	input wire logic [NBYTES*8-1:0] o_cfg_image,
	input wire logic o_cfg_loaded,
	input wire logic o_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// --------
	// Checks
	// --------
	rst_quiet_a:
		assert property ($rose(i_rstn) |-> !o_sda_oe && !o_cfg_loaded)
		else $error("port not quiet after reset");
	img_load_a:
		assert property ($rose(o_cfg_loaded) |-> o_cfg_image == i_nvm_image)
		else $error("image not loaded");
	load_hold_a:
		assert property (o_cfg_loaded |=> o_cfg_loaded)
		else $error("loaded flag dropped");
	// A write may only land while the acknowledge is on the wire.
	commit_at_ack_a:
		assert property ($past(o_cfg_loaded) && $changed(o_cfg_image) |-> $past(o_sda_oe))
		else $error("image changed outside acknowledge");
	sda_scl_low_a:
		assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
		else $error("data line moved while clock high");
	ack_len_a:
		assert property ($rose(o_sda_oe) |-> o_sda_oe[*8])
		else $error("acknowledge too short");
	oe_busy_a:
		assert property (o_sda_oe |-> o_busy)
		else $error("line driven while idle");
	ro_bytes_a:
		assert property ($past(o_cfg_loaded) |-> $stable({o_cfg_image[1871:1848],
			o_cfg_image[1839:1832], o_cfg_image[1023:880]}))
		else $error("read-only byte changed");
	// The pin is open drain, so its data bit may never be high.
	sda_o_low_a:
		assert property (!o_sda_o)
		else $error("data pin driven high");
	wr_all_a:
		assert property ($past(o_cfg_loaded) && o_cfg_image[1870] |-> $stable(o_cfg_image))
		else $error("write under full lock");
	wr_low_a:
		assert property ($past(o_cfg_loaded) && o_cfg_image[1871] |->
			$stable(o_cfg_image[1535:0]))
		else $error("write under lower lock");
endmodule

bind icp_port icp_port_chk #(.NBYTES(NBYTES), .LIVE_W(LIVE_W)) i_icp_port_chk (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda),
	.o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_nvm_image(i_nvm_image),
	.i_macro_levels(i_macro_levels), .o_cfg_image(o_cfg_image),
	.o_cfg_loaded(o_cfg_loaded), .o_busy(o_busy)
);

// File: bench/icp_master.sv
// Behavioural serial bus master on the far side of the port.
`timescale 1ns/1ps
module icp_master
(
	// Pacing clock and wire level.
	input wire logic i_clk,
	input wire logic i_sda,
	// Master drivers.
	output logic o_scl,
	output logic o_sda
);
	logic [8:0] got;
	event done;
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Data moves only in the low phase; the wire is read mid high phase.
	task automatic bitx(input logic b, output logic r);
		o_sda = b;
		w(8);
		o_scl = 1'b1;
		w(8);
		r = i_sda;
		w(8);
		o_scl = 1'b0;
		w(8);
	endtask
	task automatic start();
		o_sda = 1'b1;
		w(8);
		o_scl = 1'b1;
		w(8);
		o_sda = 1'b0;
		w(8);
		o_scl = 1'b0;
		w(8);
	endtask
	task automatic stop();
		o_sda = 1'b0;
		w(8);
		o_scl = 1'b1;
		w(8);
		o_sda = 1'b1;
		w(16);
	endtask
	task automatic xb(input logic [7:0] d, input logic a9);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], got[i+1]);
		bitx(a9, got[0]);
		-> done;
	endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the serial configuration port.
`timescale 1ns/1ps
module tb_top;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [2047:0] nvm = '0;
	logic [55:0] lv = '0;
	logic [2047:0] img;
	logic scl, m_sda, oe, sda_o, ld, busy;
	logic [8:0] exp_q[$];
	logic [8:0] e;
	logic [2:0] lk = '0;
	logic [7:0] d1, d2, d3;
	int fails = 0;
	int total_checks = 0;
	// Pulled-up wire: low if either party pulls.
	wire sda = m_sda & ~oe;
	icp_port i_icp_port (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
		.o_sda_oe(oe), .i_nvm_image(nvm), .i_macro_levels(lv), .o_cfg_image(img),
		.o_cfg_loaded(ld), .o_busy(busy)
	);
	icp_master i_icp_master (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
	initial
	begin
		forever #2.5 i_clk = ~i_clk;
	end
	// --------
	// Tasks
	// --------
	function automatic logic [7:0] nb(input logic [7:0] a);
		return nvm[a*8+:8];
	endfunction
	// Read value after a write attempt; lk is {write all, lower write, read}.
	function automatic logic [7:0] ex(input logic [7:0] a, d, input logic w);
		if (lk[0] && a < 8'hc0)
			return 8'hff;
		if (w && !lk[2] && !(lk[1] && a < 8'hc0))
			return d;
		return nb(a);
	endfunction
	task automatic tx(input logic [7:0] d, input logic a9, input logic [8:0] x);
		exp_q.push_back(x);
		i_icp_master.xb(d, a9);
	endtask
	task automatic ctl(input logic rw);
		i_icp_master.start();
		tx({7'h50, rw}, 1'b1, {7'h50, rw, 1'b0});
	endtask
	// After a stop the port must be idle and off the data line.
	task automatic idle_chk();
		total_checks++;
		if (busy !== 1'b0 || oe !== 1'b0)
		begin
			fails++;
			$display("unexpected at %0t: port still busy after stop", $time);
		end
	endtask
	task automatic wr(input logic [7:0] a, p, q, input int n);
		ctl(1'b0);
		tx(a, 1'b1, {a, 1'b0});
		tx(p, 1'b1, {p, 1'b0});
		if (n > 1)
			tx(q, 1'b1, {q, 1'b0});
		i_icp_master.stop();
		idle_chk();
	endtask
	task automatic rd(input logic [7:0] a, x, y, input int n, input logic cur);
		if (!cur)
		begin
			ctl(1'b0);
			tx(a, 1'b1, {a, 1'b0});
		end
		ctl(1'b1);
		tx(8'hff, n == 1, {x, n == 1});
		if (n > 1)
			tx(8'hff, 1'b1, {y, 1'b1});
		i_icp_master.stop();
		idle_chk();
	endtask
	task automatic boot();
		i_rstn = 1'b0;
		for (int i = 0; i < 64; i++)
			nvm[i*32+:32] = $urandom;
		nvm[1871:1864] = {lk[1] | lk[2], lk[2], 6'h0a};
		nvm[1832] = lk[0];
		lv = {24'($urandom), $urandom};
		repeat (4) @(negedge i_clk);
		i_rstn = 1'b1;
		for (int i = 0; i < 40 && ld !== 1'b1; i++)
			@(negedge i_clk);
		repeat (8) @(negedge i_clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// --------
	// Processes
	// --------
	initial
	begin
		forever
		begin
			@(i_icp_master.done);
			e = exp_q.pop_front();
			total_checks++;
			if (i_icp_master.got !== e)
			begin
				fails++;
				$display("unexpected at %0t: got %h want %h", $time, i_icp_master.got, e);
			end
		end
	end
	initial
	begin
		repeat (60000) @(posedge i_clk);
		fails++;
		tally_and_finish();
	end
	initial
	begin
		void'($urandom(32'h4db93756));
		for (int k = 0; k < 4; k++)
		begin
			lk = (k == 3) ? 3'b100 : 3'(k);
			boot();
			d1 = 8'($urandom);
			d2 = 8'($urandom);
			d3 = 8'($urandom);
			wr(8'h20, d1, d2, 2);
			rd(8'h00, ex(8'h22, d1, 1'b0), d1, 1, 1'b1);
			rd(8'h20, ex(8'h20, d1, 1'b1), ex(8'h21, d2, 1'b1), 2, 1'b0);
			wr(8'hc1, d3, d3, 1);
			rd(8'hc1, ex(8'hc1, d3, 1'b1), d3, 1, 1'b0);
			if (k == 0)
			begin
				i_icp_master.start();
				tx(8'h50, 1'b1, {8'h50, 1'b1});
				i_icp_master.stop();
				wr(8'h70, d1, d2, 2);
				rd(8'h70, nb(8'h70), nb(8'h71), 2, 1'b0);
				wr(8'he9, d3, d3, 1);
				rd(8'he9, nb(8'he9), d3, 1, 1'b0);
				rd(8'hf0, lv[7:0], lv[15:8], 2, 1'b0);
				rd(8'hf5, lv[39:32], lv[47:40], 2, 1'b0);
			end
		end
		tally_and_finish();
	end
endmodule
